// *** page_history_pkg.sv ***
package page_history_pkg;

    // ------------------------------------------------------------
    // entry layout (second word, lsb numbering)
    // ------------------------------------------------------------
    localparam logic [31:0] WORD1_OFFSET   = 32'h0000_0004;
    localparam int          REF_BIT_POS    = 8;
    localparam int          CHG_BIT_POS    = 7;
    localparam logic [3:0]  TABLE_MEM_ATTR = 4'h2;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [3:0] CTRL_OFFSET   = 4'h0;
    localparam logic [3:0] STATUS_OFFSET = 4'h4;
    localparam logic [3:0] COUNT_OFFSET  = 4'h8;
    localparam int         CTRL_EN_POS     = 0;
    localparam int         CTRL_ASSUME_POS = 1;
    localparam logic [1:0] CTRL_RESET      = 2'h1;

    typedef enum logic [3:0] {
        KIND_FETCH,
        KIND_LOAD,
        KIND_EXT_IN,
        KIND_STORE,
        KIND_EXT_OUT,
        KIND_BLOCK_ZERO,
        KIND_BLOCK_ALLOC,
        KIND_CACHE_HINT,
        KIND_TOUCH,
        KIND_BLOCK_INVAL,
        KIND_ZERO_LEN_LOAD,
        KIND_ZERO_LEN_STORE,
        KIND_COND_NO_STORE
    } access_kind_type;

    typedef struct packed {
        logic            valid;
        access_kind_type kind;
        logic            instruction_translate_enable;
        logic            data_translate_enable;
        logic            block_translation;
        logic            direct_store;
        logic            noexec_fault;
        logic            protect_fault;
        logic            speculative;
        logic            blocking_exc;
        logic            alloc_unmodified;
        logic            tlb_hit;
        logic            tlb_ref;
        logic            tlb_chg;
        logic [31:0]     pte_addr;
    } access_req_type;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [3:0]  attr;
    } mem_req_type;

    typedef struct packed {
        logic valid;
        logic set_ref;
        logic set_chg;
    } tlb_update_type;

    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_type;

endpackage

// *** page_history_bit_updater.sv ***
// Chosen here: the register addresses and the address-and-strobe port.
module page_history_bit_updater (
    input  wire logic                             clk_i,
    input  wire logic                             reset_i,
    input  wire page_history_pkg::reg_req_type    reg_req_i,
    output logic [31:0]                           reg_rdata_o,
    input  wire page_history_pkg::access_req_type acc_i,
    output logic                                  acc_ready_o,
    output page_history_pkg::tlb_update_type      tlb_update_o,
    output page_history_pkg::mem_req_type         mem_req_o,
    input  wire logic                             mem_gnt_i,
    input  wire logic                             mem_rvalid_i,
    input  wire logic [31:0]                      mem_rdata_i
);
    import page_history_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_READ,
        ST_WAIT,
        ST_WRITE
    } phase_type;

    typedef struct packed {
        phase_type      phase;
        logic [1:0]     ctrl;
        logic           pend_ref;
        logic           pend_chg;
        logic [31:0]    count;
        logic [31:0]    rdata;
        mem_req_type    mem;
        tlb_update_type tlb;
    } state_type;

    state_type state_ff;
    state_type nxt_state;

    // ------------------------------------------------------------
    // scenario classification
    // ------------------------------------------------------------
    // returns {set_ref, set_chg}; maybe outcomes resolved conservatively
    function automatic logic [1:0] classify(input access_req_type a);
        logic xlate;
        logic [1:0] res;
        xlate = (a.kind == KIND_FETCH) ? a.instruction_translate_enable : a.data_translate_enable;
        res = 2'h0;
        if (!xlate || a.block_translation || a.direct_store) begin
            res = 2'h0;
        end else if (a.noexec_fault || a.protect_fault) begin
            res = 2'h0;
        end else if (a.speculative) begin
            res = 2'h0;
        end else begin
            case (a.kind)
                KIND_ZERO_LEN_LOAD, KIND_ZERO_LEN_STORE, KIND_COND_NO_STORE: res = 2'h2;
                KIND_FETCH, KIND_LOAD, KIND_EXT_IN: res = 2'h2;
                KIND_STORE, KIND_EXT_OUT, KIND_BLOCK_ZERO: res = a.blocking_exc ? 2'h2 : 2'h3;
                KIND_BLOCK_ALLOC: begin
                    if (a.alloc_unmodified) begin
                        res = 2'h0;
                    end else begin
                        res = a.blocking_exc ? 2'h2 : 2'h3;
                    end
                end
                KIND_CACHE_HINT, KIND_TOUCH, KIND_BLOCK_INVAL: res = 2'h2;
                default: res = 2'h0;
            endcase
        end
        if (res[0]) begin
            res[1] = 1'b1;
        end
        return res;
    endfunction

    logic [1:0] outcome;
    logic       take;
    logic       need_ref;
    logic       need_chg;
    logic       enabled;
    logic       assume_ref;

    assign enabled     = state_ff.ctrl[CTRL_EN_POS];
    assign assume_ref  = state_ff.ctrl[CTRL_ASSUME_POS];
    assign outcome     = classify(acc_i);
    assign acc_ready_o = (state_ff.phase == ST_IDLE);
    assign take        = acc_i.valid && acc_ready_o;

    // ------------------------------------------------------------
    // table-update decision
    // ------------------------------------------------------------
    always_comb begin
        need_ref = 1'b0;
        need_chg = 1'b0;
        if (outcome[1] && !(acc_i.tlb_hit && (acc_i.tlb_ref || assume_ref))) begin
            need_ref = 1'b1;
        end
        if (outcome[0] && !(acc_i.tlb_hit && acc_i.tlb_chg)) begin
            need_chg = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_state.tlb = '0;
        if (reg_req_i.wr && reg_req_i.addr == CTRL_OFFSET) begin
            nxt_state.ctrl = reg_req_i.wdata[1:0];
        end
        case (state_ff.phase)
            ST_IDLE: begin
                if (take) begin
                    nxt_state.tlb.valid   = acc_i.tlb_hit && (outcome != 2'h0);
                    nxt_state.tlb.set_ref = outcome[1];
                    nxt_state.tlb.set_chg = outcome[0];
                    if (enabled && (need_ref || need_chg)) begin
                        nxt_state.pend_ref   = need_ref || need_chg;
                        nxt_state.pend_chg   = need_chg;
                        nxt_state.phase      = ST_READ;
                        nxt_state.mem.valid  = 1'b1;
                        nxt_state.mem.write  = 1'b0;
                        nxt_state.mem.addr   = acc_i.pte_addr + WORD1_OFFSET;
                        nxt_state.mem.wdata  = '0;
                        nxt_state.mem.attr   = TABLE_MEM_ATTR;
                    end
                end
            end
            ST_READ: begin
                if (mem_gnt_i) begin
                    nxt_state.mem.valid = 1'b0;
                    nxt_state.phase     = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (mem_rvalid_i) begin
                    nxt_state.rdata     = mem_rdata_i;
                    nxt_state.mem.valid = 1'b1;
                    nxt_state.mem.write = 1'b1;
                    nxt_state.mem.wdata = mem_rdata_i;
                    nxt_state.mem.wdata[REF_BIT_POS] = mem_rdata_i[REF_BIT_POS] | state_ff.pend_ref;
                    nxt_state.mem.wdata[CHG_BIT_POS] = mem_rdata_i[CHG_BIT_POS] | state_ff.pend_chg;
                    nxt_state.phase = ST_WRITE;
                end
            end
            ST_WRITE: begin
                if (mem_gnt_i) begin
                    nxt_state.mem.valid = 1'b0;
                    nxt_state.mem.write = 1'b0;
                    nxt_state.count     = state_ff.count + 32'h0000_0001;
                    nxt_state.phase     = ST_IDLE;
                end
            end
            default: begin
                nxt_state.phase = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_ff       <= '0;
            state_ff.phase <= ST_IDLE;
            state_ff.ctrl  <= CTRL_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------
    // register read
    // ------------------------------------------------------------
    logic [31:0] rdata_ff;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_ff <= '0;
        end else if (reg_req_i.rd) begin
            case (reg_req_i.addr)
                CTRL_OFFSET:   rdata_ff <= {30'h0, state_ff.ctrl};
                STATUS_OFFSET: rdata_ff <= {31'h0, state_ff.phase != ST_IDLE};
                COUNT_OFFSET:  rdata_ff <= state_ff.count;
                default:       rdata_ff <= 32'h0;
            endcase
        end else begin
            rdata_ff <= 32'h0;
        end
    end

    assign reg_rdata_o  = rdata_ff;
    assign mem_req_o    = state_ff.mem;
    assign tlb_update_o = state_ff.tlb;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_table_read;
        mem_req_o.valid && !mem_req_o.write;
    endsequence

    sequence s_table_write;
        mem_req_o.valid && mem_req_o.write;
    endsequence

    // no changed flag on the lookaside copy nor in a freshly opened table update
    sequence s_no_chg;
        !tlb_update_o.set_chg && !(mem_req_o.valid && state_ff.pend_chg);
    endsequence

    property p_untranslated_quiet;
        @(posedge clk_i) disable iff (reset_i)
        (take && (acc_i.block_translation || acc_i.direct_store)) |=> !mem_req_o.valid && !tlb_update_o.valid;
    endproperty
    a_untranslated_quiet: assert property (p_untranslated_quiet) else $error("untranslated access updated history");

    property p_xlate_off_quiet;
        @(posedge clk_i) disable iff (reset_i)
        (take && acc_i.kind == KIND_LOAD && !acc_i.data_translate_enable) |=> !mem_req_o.valid;
    endproperty
    a_xlate_off_quiet: assert property (p_xlate_off_quiet) else $error("history kept with translation off");

    property p_no_01;
        @(posedge clk_i) disable iff (reset_i)
        s_table_write |-> mem_req_o.wdata[REF_BIT_POS] || !mem_req_o.wdata[CHG_BIT_POS];
    endproperty
    a_no_01: assert property (p_no_01) else $error("changed written without referenced");

    property p_touch_no_chg;
        @(posedge clk_i) disable iff (reset_i)
        (take && acc_i.kind == KIND_TOUCH) |=> s_no_chg;
    endproperty
    a_touch_no_chg: assert property (p_touch_no_chg) else $error("touch hint set changed");

    property p_load_sets_ref;
        @(posedge clk_i) disable iff (reset_i)
        (take && enabled && acc_i.kind == KIND_LOAD && acc_i.data_translate_enable && !acc_i.block_translation
         && !acc_i.direct_store && !acc_i.noexec_fault && !acc_i.protect_fault && !acc_i.speculative
         && !acc_i.tlb_hit) |=> s_table_read;
    endproperty
    a_load_sets_ref: assert property (p_load_sets_ref) else $error("load did not start table update");

    property p_ref_kept;
        @(posedge clk_i) disable iff (reset_i)
        (state_ff.phase == ST_WAIT && mem_rvalid_i && mem_rdata_i[REF_BIT_POS]) |=> mem_req_o.wdata[REF_BIT_POS];
    endproperty
    a_ref_kept: assert property (p_ref_kept) else $error("referenced flag cleared");

    property p_chg_hit_skip;
        @(posedge clk_i) disable iff (reset_i)
        (take && acc_i.tlb_hit && acc_i.tlb_chg && (acc_i.tlb_ref || assume_ref)) |=> !mem_req_o.valid;
    endproperty
    a_chg_hit_skip: assert property (p_chg_hit_skip) else $error("redundant table update");

    property p_attr;
        @(posedge clk_i) disable iff (reset_i)
        mem_req_o.valid |-> mem_req_o.attr == TABLE_MEM_ATTR;
    endproperty
    a_attr: assert property (p_attr) else $error("wrong memory attributes");

    property p_noexec_none;
        @(posedge clk_i) disable iff (reset_i)
        (take && acc_i.noexec_fault) |=> !mem_req_o.valid && !tlb_update_o.valid;
    endproperty
    a_noexec_none: assert property (p_noexec_none) else $error("no-execute fault set a flag");

    property p_spec_no_chg;
        @(posedge clk_i) disable iff (reset_i)
        (take && acc_i.speculative) |=> !tlb_update_o.set_chg;
    endproperty
    a_spec_no_chg: assert property (p_spec_no_chg) else $error("speculative access set changed");

    property p_store_both;
        @(posedge clk_i) disable iff (reset_i)
        (take && acc_i.kind == KIND_STORE && acc_i.tlb_hit && acc_i.data_translate_enable
         && !acc_i.block_translation && !acc_i.direct_store && !acc_i.noexec_fault && !acc_i.protect_fault
         && !acc_i.speculative && !acc_i.blocking_exc) |=> tlb_update_o.valid && tlb_update_o.set_chg
         && tlb_update_o.set_ref;
    endproperty
    a_store_both: assert property (p_store_both) else $error("store did not set both flags");

    property p_preserve;
        @(posedge clk_i) disable iff (reset_i)
        (state_ff.phase == ST_WAIT && mem_rvalid_i) |=> s_table_write
        ##0 ((mem_req_o.wdata ^ state_ff.rdata) & ~(32'h1 << REF_BIT_POS) & ~(32'h1 << CHG_BIT_POS)) == 32'h0;
    endproperty
    a_preserve: assert property (p_preserve) else $error("table write altered other bits");

    property p_protect_no_chg;
        @(posedge clk_i) disable iff (reset_i)
        (take && acc_i.protect_fault) |=> s_no_chg;
    endproperty
    a_protect_no_chg: assert property (p_protect_no_chg) else $error("protection fault set changed");

    property p_blocked_no_chg;
        @(posedge clk_i) disable iff (reset_i)
        (take && acc_i.blocking_exc) |=> s_no_chg;
    endproperty
    a_blocked_no_chg: assert property (p_blocked_no_chg) else $error("store with exception set changed");

    property p_zero_len_no_chg;
        @(posedge clk_i) disable iff (reset_i)
        (take && acc_i.kind inside {KIND_ZERO_LEN_LOAD, KIND_ZERO_LEN_STORE, KIND_COND_NO_STORE}) |=> s_no_chg;
    endproperty
    a_zero_len_no_chg: assert property (p_zero_len_no_chg) else $error("zero-length access set changed");

    property p_hint_no_chg;
        @(posedge clk_i) disable iff (reset_i)
        (take && acc_i.kind inside {KIND_CACHE_HINT, KIND_BLOCK_INVAL}) |=> s_no_chg;
    endproperty
    a_hint_no_chg: assert property (p_hint_no_chg) else $error("cache hint set changed");

    property p_read_no_chg;
        @(posedge clk_i) disable iff (reset_i)
        (take && acc_i.kind inside {KIND_FETCH, KIND_LOAD, KIND_EXT_IN}) |=> s_no_chg;
    endproperty
    a_read_no_chg: assert property (p_read_no_chg) else $error("read access set changed");

    property p_fetch_sets_ref;
        @(posedge clk_i) disable iff (reset_i)
        (take && enabled && acc_i.kind == KIND_FETCH && acc_i.instruction_translate_enable && !acc_i.block_translation
         && !acc_i.direct_store && !acc_i.noexec_fault && !acc_i.protect_fault && !acc_i.speculative
         && !acc_i.tlb_hit) |=> s_table_read;
    endproperty
    a_fetch_sets_ref: assert property (p_fetch_sets_ref) else $error("fetch did not start table update");

    property p_read_addr;
        @(posedge clk_i) disable iff (reset_i)
        ($rose(mem_req_o.valid) && !mem_req_o.write) |-> mem_req_o.addr == $past(acc_i.pte_addr) + WORD1_OFFSET;
    endproperty
    a_read_addr: assert property (p_read_addr) else $error("table read not at second word");

    property p_assume_ref;
        @(posedge clk_i) disable iff (reset_i)
        (take && assume_ref && acc_i.tlb_hit && acc_i.kind == KIND_LOAD) |=> !mem_req_o.valid;
    endproperty
    a_assume_ref: assert property (p_assume_ref) else $error("assumed reference still updated table");

    property p_chg_implies_ref;
        @(posedge clk_i) disable iff (reset_i)
        tlb_update_o.set_chg |-> tlb_update_o.set_ref;
    endproperty
    a_chg_implies_ref: assert property (p_chg_implies_ref) else $error("changed without referenced");

endmodule

// *** page_history_mem_model.sv ***
module page_history_mem_model (
    input  wire logic                          clk_i,
    input  wire logic                          reset_i,
    input  wire page_history_pkg::mem_req_type mem_req_i,
    input  wire logic [3:0]                    delay_i,
    output logic                               mem_gnt_o,
    output logic                               mem_rvalid_o,
    output logic [31:0]                        mem_rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import page_history_pkg::*;

    // ------------------------------------------------------------
    // page table storage
    // ------------------------------------------------------------
    logic [31:0] words [logic [31:0]];
    logic [31:0] last_data = 32'h0;
    logic [31:0] rd_addr   = 32'h0;
    logic        rd_pend   = 1'b0;
    logic [3:0]  wait_cnt  = 4'h0;
    logic [3:0]  rd_attr   = 4'h0;
    logic [3:0]  wr_attr   = 4'h0;
    int          wr_count  = 0;

    initial begin
        mem_gnt_o    = 1'b0;
        mem_rvalid_o = 1'b0;
        mem_rdata_o  = 32'h0;
    end

    function automatic logic [31:0] get(input logic [31:0] a);
        return words.exists(a) ? words[a] : 32'h0;
    endfunction

    task automatic put(input logic [31:0] a, input logic [31:0] d);
        words[a] = d;
    endtask

    // ------------------------------------------------------------
    // grant after delay_i cycles, read data one cycle after grant
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        mem_gnt_o    <= 1'b0;
        mem_rvalid_o <= 1'b0;
        // released data line carries the inverse of the last read word, never holds the old word
        mem_rdata_o  <= ~last_data;
        if (reset_i) begin
            rd_pend  <= 1'b0;
            wait_cnt <= 4'h0;
        end else begin
            if (rd_pend) begin
                rd_pend      <= 1'b0;
                mem_rvalid_o <= 1'b1;
                mem_rdata_o  <= get(rd_addr);
                last_data    <= get(rd_addr);
            end
            if (mem_req_i.valid && !mem_gnt_o) begin
                if (wait_cnt < delay_i) begin
                    wait_cnt <= wait_cnt + 4'h1;
                end else begin
                    mem_gnt_o <= 1'b1;
                    wait_cnt  <= 4'h0;
                    if (mem_req_i.write) begin
                        words[mem_req_i.addr] = mem_req_i.wdata;
                        wr_attr  <= mem_req_i.attr;
                        wr_count++;
                    end else begin
                        rd_pend <= 1'b1;
                        rd_addr <= mem_req_i.addr;
                        rd_attr <= mem_req_i.attr;
                    end
                end
            end
        end
    end
endmodule

// *** page_history_bit_updater_tb_top.sv ***
module page_history_bit_updater_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import page_history_pkg::*;

    logic           clk_i        = 1'b0;
    logic           reset_i      = 1'b1;
    reg_req_type    reg_req_i    = '0;
    access_req_type acc_i        = '0;
    logic [3:0]     stall        = 4'h0;
    logic [31:0]    reg_rdata_o;
    logic           acc_ready_o;
    tlb_update_type tlb_update_o;
    mem_req_type    mem_req_o;
    logic           mem_gnt_i;
    logic           mem_rvalid_i;
    logic [31:0]    mem_rdata_i;
    int             bad_count    = 0;
    int             total_checks = 0;
    int             exp_cnt      = 0;
    localparam logic [31:0] PAT  = 32'ha5a5_fe7f;
    localparam logic [31:0] PAT2 = 32'h5a5a_8125;
    access_kind_type ref_kinds [9] = '{KIND_FETCH, KIND_LOAD, KIND_EXT_IN, KIND_ZERO_LEN_LOAD, KIND_ZERO_LEN_STORE,
                                       KIND_COND_NO_STORE, KIND_CACHE_HINT, KIND_TOUCH, KIND_BLOCK_INVAL};
    access_kind_type chg_kinds [4] = '{KIND_STORE, KIND_EXT_OUT, KIND_BLOCK_ZERO, KIND_BLOCK_ALLOC};

    always #5 clk_i = ~clk_i;

    page_history_bit_updater dut (
        .clk_i        (clk_i),
        .reset_i      (reset_i),
        .reg_req_i    (reg_req_i),
        .reg_rdata_o  (reg_rdata_o),
        .acc_i        (acc_i),
        .acc_ready_o  (acc_ready_o),
        .tlb_update_o (tlb_update_o),
        .mem_req_o    (mem_req_o),
        .mem_gnt_i    (mem_gnt_i),
        .mem_rvalid_i (mem_rvalid_i),
        .mem_rdata_i  (mem_rdata_i)
    );

    page_history_mem_model mem (
        .clk_i        (clk_i),
        .reset_i      (reset_i),
        .mem_req_i    (mem_req_o),
        .delay_i      (stall),
        .mem_gnt_o    (mem_gnt_i),
        .mem_rvalid_o (mem_rvalid_i),
        .mem_rdata_o  (mem_rdata_i)
    );

    // ------------------------------------------------------------
    // checking and register access
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    task automatic reg_wr(input logic [3:0] addr, input logic [31:0] data);
        @(posedge clk_i);
        reg_req_i.wr    <= 1'b1;
        reg_req_i.addr  <= addr;
        reg_req_i.wdata <= data;
        @(posedge clk_i);
        reg_req_i.wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [3:0] addr, input logic [31:0] exp);
        @(posedge clk_i);
        reg_req_i.rd   <= 1'b1;
        reg_req_i.addr <= addr;
        @(posedge clk_i);
        reg_req_i.rd <= 1'b0;
        #1;
        chk(reg_rdata_o === exp, "register read");
    endtask

    function automatic access_req_type mk(input access_kind_type k, input int idx);
        access_req_type a;
        a = '0;
        a.valid = 1'b1;
        a.kind = k;
        a.instruction_translate_enable = 1'b1;
        a.data_translate_enable = 1'b1;
        a.tlb_hit = 1'b1;
        a.pte_addr = 32'h0000_1000 + 32'(idx * 16);
        return a;
    endfunction

    // one access; er/ec wanted flags, upd table write expected, ct check lookaside pulse
    task automatic run(input access_req_type a, input logic [31:0] p, input logic er, input logic ec,
                       input logic upd, input logic ct);
        int          n;
        int          wc;
        logic [31:0] w;
        w = a.pte_addr + WORD1_OFFSET;
        mem.put(w, p);
        wc = mem.wr_count;
        @(posedge clk_i);
        acc_i <= a;
        @(posedge clk_i);
        acc_i.valid <= 1'b0;
        #1;
        if (ct) chk(tlb_update_o.valid === (a.tlb_hit & (er | ec)) && (tlb_update_o.valid !== 1'b1 ||
            (tlb_update_o.set_ref === (er | ec) && tlb_update_o.set_chg === ec)), "lookaside update");
        n = 0;
        while (acc_ready_o !== 1'b1 && n < 60) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        if (n >= 60) begin
            chk(1'b0, "access never finished");
            finish_test();
        end
        chk(mem.get(w) === (upd ? (p | {23'h0, er, ec, 7'h0}) : p), "table word");
        chk(mem.wr_count - wc === (upd ? 1 : 0), "table write count");
        if (upd) chk(mem.rd_attr === TABLE_MEM_ATTR && mem.wr_attr === TABLE_MEM_ATTR, "attributes");
        exp_cnt += int'(upd);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        access_req_type a;
        repeat (6) @(posedge clk_i);
        reset_i <= 1'b0;
        reg_rd(CTRL_OFFSET, {30'h0, CTRL_RESET});
        reg_rd(STATUS_OFFSET, 32'h0);
        reg_rd(COUNT_OFFSET, 32'h0);
        reg_rd(4'hc, 32'h0);
        reg_wr(STATUS_OFFSET, 32'hffff_ffff);
        reg_rd(STATUS_OFFSET, 32'h0);
        $display("test register reset done");
        for (int i = 0; i < 9; i++) begin
            a = mk(ref_kinds[i], i);
            a.tlb_hit = i[0];
            stall <= i[1] ? 4'h3 : 4'h0;
            run(a, PAT, 1'b1, 1'b0, 1'b1, 1'b1);
        end
        $display("test referenced-only kinds done");
        for (int i = 0; i < 4; i++) begin
            a = mk(chg_kinds[i], i + 9);
            a.tlb_hit = i[0];
            run(a, PAT, 1'b1, 1'b1, 1'b1, 1'b1);
        end
        $display("test changed kinds done");
        a = mk(KIND_STORE, 20);
        a.instruction_translate_enable = 1'b0;
        a.data_translate_enable = 1'b0;
        run(a, PAT, 1'b0, 1'b0, 1'b0, 1'b1);
        a = mk(KIND_LOAD, 21);
        a.block_translation = 1'b1;
        run(a, PAT, 1'b0, 1'b0, 1'b0, 1'b1);
        a = mk(KIND_STORE, 22);
        a.direct_store = 1'b1;
        run(a, PAT, 1'b0, 1'b0, 1'b0, 1'b1);
        a = mk(KIND_FETCH, 23);
        a.noexec_fault = 1'b1;
        a.protect_fault = 1'b1;
        a.speculative = 1'b1;
        run(a, PAT, 1'b0, 1'b0, 1'b0, 1'b1);
        a = mk(KIND_STORE, 24);
        a.protect_fault = 1'b1;
        run(a, PAT, 1'b0, 1'b0, 1'b0, 1'b1);
        a = mk(KIND_STORE, 25);
        a.speculative = 1'b1;
        run(a, PAT, 1'b0, 1'b0, 1'b0, 1'b1);
        a = mk(KIND_STORE, 26);
        a.blocking_exc = 1'b1;
        run(a, PAT, 1'b1, 1'b0, 1'b1, 1'b1);
        a = mk(KIND_BLOCK_ALLOC, 27);
        a.alloc_unmodified = 1'b1;
        run(a, PAT, 1'b0, 1'b0, 1'b0, 1'b1);
        $display("test suppressed scenarios done");
        a = mk(KIND_STORE, 28);
        a.tlb_ref = 1'b1;
        a.tlb_chg = 1'b1;
        run(a, PAT, 1'b1, 1'b1, 1'b0, 1'b0);
        a.tlb_chg = 1'b0;
        run(a, PAT, 1'b1, 1'b1, 1'b1, 1'b0);
        a = mk(KIND_LOAD, 29);
        a.tlb_hit = 1'b0;
        run(a, PAT2, 1'b1, 1'b0, 1'b1, 1'b1);
        a = mk(KIND_STORE, 30);
        run(a, PAT2, 1'b1, 1'b1, 1'b1, 1'b1);
        $display("test lookaside state done");
        reg_wr(CTRL_OFFSET, 32'h0);
        reg_rd(CTRL_OFFSET, 32'h0);
        run(mk(KIND_STORE, 31), PAT, 1'b1, 1'b1, 1'b0, 1'b0);
        reg_wr(CTRL_OFFSET, 32'h3);
        run(mk(KIND_LOAD, 32), PAT, 1'b1, 1'b0, 1'b0, 1'b0);
        reg_wr(CTRL_OFFSET, 32'h1);
        // busy flag seen while a slow table update is open
        stall <= 4'h8;
        @(posedge clk_i);
        acc_i <= mk(KIND_LOAD, 33);
        @(posedge clk_i);
        acc_i.valid <= 1'b0;
        reg_rd(STATUS_OFFSET, 32'h1);
        repeat (40) @(posedge clk_i);
        exp_cnt++;
        reg_rd(STATUS_OFFSET, 32'h0);
        chk(mem.get(32'h0000_1214) === 32'h0000_0100, "busy table word");
        reg_rd(COUNT_OFFSET, 32'(exp_cnt));
        $display("test control and count done");
        finish_test();
    end
endmodule
